// file: verilog/rcs_pkg.sv
// package for the reset and clock-start sequencer
// assumes one system clock standing in for the oscillator-select clock
package rcs_pkg;
  // --------------------------------------------------------------
  // timing, counted in oscillator-select clock cycles
  // --------------------------------------------------------------
  localparam int RCS_CNT_W = 13;
  localparam logic [12:0] RCS_LONG_CYC = 13'h1000;
  localparam logic [12:0] RCS_SHORT_CYC = 13'h0020;
  localparam logic [12:0] RCS_PIN_CYC = 13'h0020;
  localparam logic [12:0] RCS_HOLD_CYC = 13'h0020;
  localparam logic [6:0] RCS_PIN_MIN_CYC = 7'h43;
  localparam logic [1:0] RCS_BUS_DIV = 2'h3;
  // --------------------------------------------------------------
  // reset vectors
  // --------------------------------------------------------------
  localparam logic [15:0] RCS_VEC_USER = 16'hFFFE;
  localparam logic [15:0] RCS_VEC_MON = 16'hFEFE;
  // --------------------------------------------------------------
  // cause register bit positions and reset value
  // --------------------------------------------------------------
  localparam int RCS_B_POR = 7;
  localparam int RCS_B_PIN = 6;
  localparam int RCS_B_WDOG = 5;
  localparam int RCS_B_BADOP = 4;
  localparam int RCS_B_BADAD = 3;
  localparam int RCS_B_MON = 1;
  localparam int RCS_B_LV = 0;
  localparam logic [7:0] RCS_CAUSE_RST = 8'h80;
  localparam logic [7:0] RCS_CAUSE_POR = 8'h80;
  // --------------------------------------------------------------
  // register map
  // --------------------------------------------------------------
  localparam logic [3:0] RCS_A_CAUSE = 4'h0;
  localparam logic [3:0] RCS_A_CONFIG = 4'h1;
  localparam logic [3:0] RCS_A_STATUS = 4'h2;
  localparam logic [1:0] RCS_CFG_RST = 2'h0;
  localparam int RCS_CFG_SHORT_STOP_RECOVERY = 0;
  localparam int RCS_CFG_STOPEN = 1;

  typedef enum logic [2:0] {
    RCS_RUN = 3'b000,
    RCS_OSC = 3'b001,
    RCS_PIN = 3'b010,
    RCS_HOLD = 3'b011,
    RCS_STOP = 3'b100,
    RCS_SREC = 3'b101,
    RCS_EXT = 3'b110
  } rcs_state_t;
endpackage : rcs_pkg

// file: verilog/rcs_sequencer.sv
// reset and clock-start sequencer: reset sources, reset pin, clock gates
// assumes clk_sys is the oscillator-select clock, resetn is power-on
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - bus clock is oscillator clock over four
// - power-on/low-voltage: clocks off, pin low 4096+32
// - stop exit waits 32 or 4096 cycles
// - wait mode gates only cpu clock
// - every reset selects user or monitor vector
// - internal reset returns modules to defaults
// - internal reset clears counter, pin reset not
// - each source sets its own cause flag
// - pin flag needs 67 cycles low
// - internal reset: pin 32, then 32 more
// - power-on: pin 4096+32, release 32 later
// - power-on sets its flag, clears others
// - watchdog overflow resets, sets its flag
// - watchdog disable only by test voltage
// - undefined instruction resets, sets flag
// - stop without enable counts as illegal
// - only opcode fetch from hole resets
// - low voltage: flag, pin 4096+32, then 32
// - monitor-entry request forces internal reset
// - sequencing counter is thirteen bits
// - stop clears counter; free runs after reset
// - low reset pin halts all processing
module rcs_sequencer
  import rcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic low_voltage_trip,
  input wire logic watchdog_overflow,
  input wire logic illegal_decode,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic wake_event,
  input wire logic fetch_unmapped,
  input wire logic fetch_is_opcode,
  input wire logic monitor_entry_reset,
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic rst_test_high_voltage,
  input wire logic irq_test_high_voltage,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic internal_reset,
  output logic [15:0] reset_vector,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic bus_clk_en,
  output logic watchdog_disable
);
  // ----------------------------------------------------------------
  // pin synchroniser: three stages, change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------
  // reset to the idle high level so release shows no false edge;
  // only the second and third stage decide, the first may be metastable
  logic [2:0] pin_sync_r;
  logic pin_low_r;
  logic pin_low_nxt;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_sync_r <= 3'h7;
      pin_low_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], rst_pin_in};
      pin_low_r <= pin_low_nxt;
    end
  end
  assign pin_low_nxt = (pin_sync_r[1] == pin_sync_r[2]) ? ~pin_sync_r[2]
                                                       : pin_low_r;

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  rcs_state_t state_r;
  rcs_state_t state_nxt;
  logic [RCS_CNT_W-1:0] cnt_r;
  logic [RCS_CNT_W-1:0] cnt_nxt;
  logic [RCS_CNT_W-1:0] phase_r;
  logic [RCS_CNT_W-1:0] phase_nxt;
  logic [6:0] ext_cnt_r;
  logic [7:0] cause_r;
  logic [7:0] cause_nxt;
  logic [1:0] cfg_r;
  logic [1:0] div_r;
  logic long_seq_r;
  logic wait_r;
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // reset source decode
  // ----------------------------------------------------------------
  // stop without enable is illegal
  wire stop_bad = stop_exec & ~cfg_r[RCS_CFG_STOPEN];
  wire stop_ok = stop_exec & cfg_r[RCS_CFG_STOPEN];
  wire src_badop = illegal_decode | stop_bad;
  wire src_badad = fetch_unmapped & fetch_is_opcode;
  wire src_wdog = watchdog_overflow & ~watchdog_disable;
  wire src_mon = monitor_entry_reset;
  wire src_lv = low_voltage_trip;
  wire src_int = src_badop | src_badad | src_wdog | src_mon | src_lv;
  wire running = (state_r == RCS_RUN);
  // sources are only taken while running so one sequence owns the pin
  wire int_start = running & src_int;
  wire ext_start = running & pin_low_r & ~src_int;
  // phase_r holds the end point of the phase in progress
  wire phase_done = (cnt_r == phase_r - 13'h0001);
  wire short_stop_recovery = cfg_r[RCS_CFG_SHORT_STOP_RECOVERY];

  // ----------------------------------------------------------------
  // sequencing state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r + 13'h0001;
    unique case (state_r)
      RCS_RUN: begin
        if (int_start) begin
          cnt_nxt = '0;
          if (src_lv) begin
            state_nxt = RCS_OSC;
            phase_nxt = RCS_LONG_CYC;
          end else begin
            state_nxt = RCS_PIN;
            phase_nxt = RCS_PIN_CYC;
          end
        end else if (ext_start) begin
          state_nxt = RCS_EXT;
        end else if (stop_ok) begin
          cnt_nxt = '0;
          state_nxt = RCS_STOP;
        end
      end
      RCS_OSC: begin
        if (phase_done) begin
          cnt_nxt = '0;
          state_nxt = RCS_PIN;
          phase_nxt = RCS_PIN_CYC;
        end
      end
      RCS_PIN: begin
        if (phase_done) begin
          cnt_nxt = '0;
          state_nxt = RCS_HOLD;
          phase_nxt = RCS_HOLD_CYC;
        end
      end
      RCS_HOLD: begin
        if (phase_done) begin
          // a pin still held low hands over to the pin-reset wait
          state_nxt = pin_low_r ? RCS_EXT : RCS_RUN;
        end
      end
      RCS_STOP: begin
        if (wake_event || pin_low_r) begin
          cnt_nxt = '0;
          state_nxt = RCS_SREC;
          phase_nxt = short_stop_recovery ? RCS_SHORT_CYC : RCS_LONG_CYC;
        end else begin
          // counter frozen in stop; recovery restarts it from zero
          cnt_nxt = cnt_r;
        end
      end
      RCS_SREC: begin
        // a pin still low at the end of recovery becomes a pin reset
        if (phase_done) begin
          state_nxt = pin_low_r ? RCS_EXT : RCS_RUN;
        end
      end
      RCS_EXT: begin
        if (!pin_low_r) begin
          state_nxt = RCS_HOLD;
          // hold end measured from wherever the free counter stands
          phase_nxt = cnt_r + RCS_HOLD_CYC + 13'h0001;
        end
      end
      default: begin
        state_nxt = RCS_OSC;
        phase_nxt = RCS_LONG_CYC;
        cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= RCS_OSC;
      phase_r <= RCS_LONG_CYC;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pin-low duration, for the pin cause flag
  // ----------------------------------------------------------------
  // saturates so a long hold cannot wrap back onto the flag count
  wire ext_cnt_sat = (ext_cnt_r == RCS_PIN_MIN_CYC);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ext_cnt_r <= '0;
    end else if (!pin_low_r) begin
      ext_cnt_r <= '0;
    end else if (!ext_cnt_sat) begin
      ext_cnt_r <= ext_cnt_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // cause flags
  // ----------------------------------------------------------------
  // long-path flag keeps pin credit off power-on and low-voltage resets
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      long_seq_r <= 1'b1;
    end else if (int_start) begin
      long_seq_r <= src_lv;
    end else if (state_r == RCS_RUN) begin
      long_seq_r <= 1'b0;
    end
  end

  always_comb begin
    cause_nxt = cause_r;
    // bit 2 has no source and always reads zero
    // reading the cause register clears it
    if (reg_rd && reg_addr == RCS_A_CAUSE) begin
      cause_nxt = '0;
    end
    // new causes win over the read clear
    if (int_start) begin
      cause_nxt[RCS_B_BADOP] = src_badop;
      cause_nxt[RCS_B_BADAD] = src_badad;
      cause_nxt[RCS_B_WDOG] = src_wdog;
      cause_nxt[RCS_B_MON] = src_mon;
      cause_nxt[RCS_B_LV] = src_lv;
      cause_nxt[RCS_B_POR] = 1'b0;
      cause_nxt[RCS_B_PIN] = 1'b0;
    end
    // a long enough hold replaces any earlier cause
    // pin flag after 67 low cycles
    if (ext_cnt_r == RCS_PIN_MIN_CYC - 7'h01 && !long_seq_r) begin
      cause_nxt = '0;
      cause_nxt[RCS_B_PIN] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cause_r <= RCS_CAUSE_POR;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // unmapped addresses read zero; config ignores writes in reset
  wire cfg_wr = reg_wr & (reg_addr == RCS_A_CONFIG);
  wire [7:0] status_word = {4'h0, wait_r, state_r};
  wire [7:0] rd_mux = (reg_addr == RCS_A_CAUSE) ? cause_r :
                      (reg_addr == RCS_A_CONFIG) ? {6'h00, cfg_r} :
                      (reg_addr == RCS_A_STATUS) ? status_word : 8'h00;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= RCS_CFG_RST;
      rdata_r <= 8'h00;
    end else begin
      // config returns to default in reset
      if (internal_reset) begin
        cfg_r <= RCS_CFG_RST;
      end else if (cfg_wr) begin
        cfg_r <= reg_wdata[1:0];
      end
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // clock gating and outputs
  // ----------------------------------------------------------------
  wire in_reset = ~running;
  wire run_nxt = (state_nxt == RCS_RUN);
  // pull the pin only in the long and pin phases
  wire pin_drive_nxt = (state_nxt == RCS_OSC) || (state_nxt == RCS_PIN);
  // stop and its recovery gate clocks but are no reset
  wire rst_nxt = ~(run_nxt || state_nxt == RCS_STOP ||
                   state_nxt == RCS_SREC);
  // clocks only outside reset and stop
  wire cpu_en_nxt = run_nxt & ~wait_r & ~wait_exec;
  wire bus_en_nxt = run_nxt & (div_r == RCS_BUS_DIV);
  // test-voltage decode, retimed by one flop
  wire wdog_dis_nxt = (monitor_mode &
                       (rst_test_high_voltage | irq_test_high_voltage)) |
                      (break_state & rst_test_high_voltage);
  wire [15:0] vec_nxt = monitor_mode ? RCS_VEC_MON : RCS_VEC_USER;
  wire [1:0] div_nxt = (in_reset || div_r == RCS_BUS_DIV) ? 2'h0
                                                          : div_r + 2'h1;
  wire wait_nxt = (in_reset || wake_event) ? 1'b0 : (wait_r | wait_exec);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
      wait_r <= 1'b0;
      reset_vector <= RCS_VEC_USER;
      watchdog_disable <= 1'b0;
    end else begin
      div_r <= div_nxt;
      wait_r <= wait_nxt;
      reset_vector <= vec_nxt;
      watchdog_disable <= wdog_dis_nxt;
    end
  end

  // power-on picture: pin pulled low, internal reset on, clocks held
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= 1'b0;
      internal_reset <= 1'b1;
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      bus_clk_en <= 1'b0;
    end else begin
      // pin level is always low; only the enable moves
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= ~pin_drive_nxt;
      internal_reset <= rst_nxt;
      cpu_clk_en <= cpu_en_nxt;
      periph_clk_en <= run_nxt;
      bus_clk_en <= bus_en_nxt;
    end
  end
endmodule : rcs_sequencer

// file: sim/rcs_seq_asserts.sv
// checker for the reset and clock-start sequencer ports
// assumes it is bound into rcs_sequencer, clk_sys as oscillator clock
`timescale 1ns/10ps
module rcs_seq_asserts
  import rcs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic watchdog_overflow,
  input wire logic illegal_decode,
  input wire logic wait_exec,
  input wire logic monitor_mode,
  input wire logic break_state,
  input wire logic rst_test_high_voltage,
  input wire logic irq_test_high_voltage,
  input wire logic internal_reset,
  input wire logic [15:0] reset_vector,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic bus_clk_en,
  input wire logic watchdog_disable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [12:0] low_cnt_r;
  logic dis_cond;
  assign dis_cond = monitor_mode && (rst_test_high_voltage ||
    irq_test_high_voltage) || break_state && rst_test_high_voltage;
  // counts only cycles in which the device itself pulls the pin
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt_r <= 13'h0000;
    end else begin
      low_cnt_r <= rst_pin_oe_n ? 13'h0000 : low_cnt_r + 13'h0001;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_pin_only_low: assert property (rst_pin_out == 1'b0)
    else $error("reset pin driven high");
  a_pin_low_len: assert property ($rose(rst_pin_oe_n) |->
    (low_cnt_r > 13'h001B && low_cnt_r < 13'h0025) ||
    (low_cnt_r > 13'h1017 && low_cnt_r < 13'h1029))
    else $error("reset pin low time wrong");
  a_hold_after_pin: assert property ($rose(rst_pin_oe_n) |->
    internal_reset [*8] ##[20:30] !internal_reset)
    else $error("internal reset hold wrong");
  a_clk_off_long: assert property (!rst_pin_oe_n &&
    low_cnt_r > 13'h0040 |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks run during oscillator timeout");
  a_bus_div_four: assert property (bus_clk_en && periph_clk_en |=>
    !bus_clk_en [*3] ##1 (bus_clk_en || !periph_clk_en))
    else $error("bus clock not divided by four");
  // sources are ignored in stop, where the peripheral clock is off
  a_wdog_reset: assert property (watchdog_overflow &&
    !watchdog_disable && !internal_reset && periph_clk_en |=>
    internal_reset && !rst_pin_oe_n)
    else $error("watchdog overflow gave no reset");
  a_badop_reset: assert property (illegal_decode &&
    !internal_reset && periph_clk_en |=> internal_reset && !rst_pin_oe_n)
    else $error("illegal opcode gave no reset");
  a_vector_sel: assert property ($past(resetn) |-> reset_vector ==
    ($past(monitor_mode) ? RCS_VEC_MON : RCS_VEC_USER))
    else $error("reset vector wrong");
  a_wdog_disable: assert property ($past(resetn) |->
    watchdog_disable == $past(dis_cond))
    else $error("watchdog disable wrong");
  a_wait_gate: assert property (wait_exec && cpu_clk_en &&
    !internal_reset |-> ##[1:2] (!cpu_clk_en && periph_clk_en))
    else $error("wait mode clock gating wrong");
  c_pin_release: cover property ($rose(rst_pin_oe_n));
  c_wdog: cover property (watchdog_overflow && !internal_reset);
  c_wait: cover property (wait_exec && cpu_clk_en);
endmodule : rcs_seq_asserts

bind rcs_sequencer rcs_seq_asserts rcs_seq_asserts_i (.clk_sys(clk_sys),
  .resetn(resetn), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
  .watchdog_overflow(watchdog_overflow), .illegal_decode(illegal_decode),
  .wait_exec(wait_exec), .monitor_mode(monitor_mode),
  .break_state(break_state), .rst_test_high_voltage(rst_test_high_voltage),
  .irq_test_high_voltage(irq_test_high_voltage),
  .internal_reset(internal_reset), .reset_vector(reset_vector),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .bus_clk_en(bus_clk_en), .watchdog_disable(watchdog_disable));

// file: sim/rcs_pin_partner.sv
// reset line model: pull-up plus outside chips that may pull low
// assumes the sequencer splits its pin into level, out and enable
`timescale 1ns/10ps
module rcs_pin_partner (
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic ext_hold_low,
  output logic rst_pin_in
);
  assign rst_pin_in = (ext_hold_low || (!rst_pin_oe_n && !rst_pin_out)) ?
    1'b0 : 1'b1;
endmodule : rcs_pin_partner

// file: sim/tb_rcs_sequencer.sv
// self-checking bench for the reset and clock-start sequencer
// assumes the pin model gives the pulled-up reset line
`timescale 1ns/10ps
module tb_rcs_sequencer;
  import rcs_pkg::*;
  logic clk_sys, resetn, rst_pin_in, rst_pin_out, rst_pin_oe_n;
  logic ext_hold_low, wake_event, fetch_is_opcode, reg_wr, reg_rd;
  logic internal_reset, cpu_clk_en, periph_clk_en, bus_clk_en;
  logic watchdog_disable, monitor_mode, break_state;
  logic rst_test_high_voltage, irq_test_high_voltage;
  logic [6:0] src;
  logic [3:0] reg_addr, tv;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] reset_vector;
  int fails, checks_done;
  always #2 clk_sys = ~clk_sys;
  rcs_sequencer rcs_sequencer_i (.clk_sys, .resetn, .rst_pin_in,
    .rst_pin_out, .rst_pin_oe_n, .low_voltage_trip(src[4]),
    .watchdog_overflow(src[0]), .illegal_decode(src[1]),
    .stop_exec(src[5]), .wait_exec(src[6]), .wake_event,
    .fetch_unmapped(src[2]), .fetch_is_opcode,
    .monitor_entry_reset(src[3]), .monitor_mode, .break_state,
    .rst_test_high_voltage, .irq_test_high_voltage, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .internal_reset,
    .reset_vector, .cpu_clk_en, .periph_clk_en, .bus_clk_en,
    .watchdog_disable);
  rcs_pin_partner rcs_pin_partner_i (.rst_pin_out, .rst_pin_oe_n,
    .ext_hold_low, .rst_pin_in);
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string s, input logic [15:0] e, d);
    checks_done++;
    if (d !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", s, e, d);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  task automatic pulse(input logic [6:0] v);
    @(posedge clk_sys);
    src <= v;
    @(posedge clk_sys);
    src <= 7'h00;
  endtask : pulse
  task automatic wake;
    @(posedge clk_sys);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
  endtask : wake
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk($sformatf("rdata_%h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  // bounded wait for the internal reset to end
  task automatic wait_run;
    int n;
    n = 0;
    tick(2);
    while (internal_reset !== 1'b0) begin
      n++;
      if (n > 6000) begin
        fails++;
        test_done();
      end
      @(posedge clk_sys);
    end
    tick(2);
  endtask : wait_run
  // stop with stop disabled reads back as a bad opcode
  function automatic logic [7:0] cause_of(input int k);
    case (k)
      0: return 8'h20;
      1, 5: return 8'h10;
      2: return 8'h08;
      3: return 8'h02;
      default: return 8'h01;
    endcase
  endfunction : cause_of
  function automatic logic dis_exp(input logic [3:0] t);
    return t[3] & (t[1] | t[0]) | t[2] & t[1];
  endfunction : dis_exp
  task automatic fire(input int k);
    pulse(7'h01 << k);
    wait_run();
    rd(RCS_A_CAUSE, cause_of(k));
  endtask : fire
  task automatic pin_rst(input int n, input logic [7:0] e);
    @(posedge clk_sys);
    ext_hold_low <= 1'b1;
    tick(n);
    ext_hold_low <= 1'b0;
    wait_run();
    rd(RCS_A_CAUSE, e);
  endtask : pin_rst
  task automatic stop_rec(input logic ss, input int lo, input int hi);
    int n;
    wr(RCS_A_CONFIG, {6'h00, 1'b1, ss});
    rd(RCS_A_CONFIG, {6'h00, 1'b1, ss});
    pulse(7'h20);
    tick(3);
    chk("cpu_clk_en", 16'h0000, {15'h0000, cpu_clk_en});
    wake();
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 5000) begin
      fails++;
      test_done();
    end
    chk("stop_wake", 16'h0001, {15'h0000, n >= lo && n <= hi});
  endtask : stop_rec
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    #400000;
    fails++;
    test_done();
  end
  initial begin
    {clk_sys, resetn, ext_hold_low, wake_event, reg_wr, reg_rd} = 6'h00;
    {monitor_mode, break_state} = 2'h0;
    {rst_test_high_voltage, irq_test_high_voltage} = 2'h0;
    {fetch_is_opcode, src, reg_addr, reg_wdata, tv} = 24'h800000;
    fails = 0;
    checks_done = 0;
    void'($urandom(32'hAC71));
    tick(8);
    resetn <= 1'b1;
    wait_run();
    rd(RCS_A_CAUSE, 8'h80);
    rd(RCS_A_CAUSE, 8'h00);
    rd(RCS_A_CONFIG, 8'h00);
    rd(4'hF, 8'h00);
    rd(RCS_A_STATUS, 8'h00);
    for (int k = 0; k < 6; k++) fire(k);
    repeat (6) begin
      tick($urandom_range(9, 1));
      fire($urandom_range(3, 0));
    end
    fetch_is_opcode <= 1'b0;
    pulse(7'h04);
    tick(3);
    chk("internal_reset", 16'h0000, {15'h0000, internal_reset});
    fetch_is_opcode <= 1'b1;
    pin_rst(80, 8'h40);
    pin_rst(20, 8'h00);
    for (int i = 0; i < 9; i++) begin
      tv = (i == 8) ? 4'hA : 4'($urandom);
      {monitor_mode, break_state} <= tv[3:2];
      {rst_test_high_voltage, irq_test_high_voltage} <= tv[1:0];
      tick(3);
      chk("wdog_dis", {15'h0, dis_exp(tv)}, {15'h0, watchdog_disable});
      chk("reset_vector", tv[3] ? 16'hFEFE : 16'hFFFE, reset_vector);
    end
    pulse(7'h01);
    tick(3);
    chk("internal_reset", 16'h0000, {15'h0000, internal_reset});
    {monitor_mode, break_state} <= 2'h0;
    {rst_test_high_voltage, irq_test_high_voltage} <= 2'h0;
    pulse(7'h40);
    tick(3);
    chk("clk_en", 16'h0001, {14'h0000, cpu_clk_en, periph_clk_en});
    rd(RCS_A_STATUS, 8'h08);
    wake();
    tick(4);
    stop_rec(1'b1, 28, 40);
    stop_rec(1'b0, 4090, 4110);
    // second power-on in the middle of a watchdog reset sequence, with its cause still pending
    pulse(7'h01);
    tick(2);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    wait_run();
    rd(RCS_A_CAUSE, 8'h80);
    test_done();
  end
endmodule : tb_rcs_sequencer
